// ===== rtl/tpc_mode_ctrl.sv
`default_nettype none

module tpc_mode_ctrl
#(
   parameter int unsigned TICK_CYCLES = tpc_pkg::TICK_CYCLES_DFLT,
   parameter int unsigned INIT_TICKS  = tpc_pkg::INIT_TICKS_DFLT
)
(
   input  wire logic        MCLK,
   input  wire logic        HOST_RESET_N,
   input  wire logic        SCL_I,
   input  wire logic        SDA_I,
   output logic             SDA_O,
   output logic             SDA_OE,
   output logic             TOUCH_IRQ_N,
   output tpc_pkg::tpc_mode_t MODE,
   output logic             PFE_SCAN_START,
   output logic             PFE_FULL_SCAN,
   output logic             PFE_POWER_DOWN,
   input  wire logic        PFE_DONE,
   input  wire logic        PFE_TOUCH,
   input  wire logic [11:0] PFE_X,
   input  wire logic [11:0] PFE_Y
);
   import tpc_pkg::*;

   tpc_mode_t   mode;
   logic [15:0] tick_cnt;
   logic        ms_tick;
   logic [15:0] init_cnt;
   logic        init_done;
   logic [10:0] phase;
   logic [10:0] next_phase;
   logic [7:0]  act_fps;
   logic [7:0]  mon_fps;
   logic        scan_busy;
   logic        scan_due;
   logic        data_ready;
   logic        touched;
   logic [11:0] x_pos;
   logic [11:0] y_pos;
   logic [7:0]  ptr;
   logic [7:0]  rd_data;
   logic        port_en;
   logic        wr_valid;
   logic        wr_first;
   logic [7:0]  wr_data;
   logic        rd_take;
   logic        done_ok;
   logic        reg_wr;

   assign MODE           = mode;
   assign SDA_O          = 1'b0;
   assign PFE_FULL_SCAN  = (mode == MODE_ACTIVE);
   assign PFE_POWER_DOWN = (mode == MODE_HIBERNATE);
   // A finished scan is only honoured while one is outstanding.
   assign done_ok        = PFE_DONE && scan_busy;
   assign reg_wr         = wr_valid && !wr_first;

   // ****************************************************************
   // Serial port
   // ****************************************************************
   // The port is held shut until start-up is over, which also covers
   // stray traffic during the reset interval.
   assign port_en = (mode == MODE_ACTIVE) && init_done;

   tpc_i2c_target u_port
   (
      .clk      (MCLK),
      .rst_n    (HOST_RESET_N),
      .enable   (port_en),
      .scl      (SCL_I),
      .sda      (SDA_I),
      .sda_oe   (SDA_OE),
      .wr_valid (wr_valid),
      .wr_first (wr_first),
      .wr_data  (wr_data),
      .rd_take  (rd_take),
      .rd_data  (rd_data)
   );

   // ****************************************************************
   // Millisecond tick and start-up delay
   // ****************************************************************
   // The tick stops in hibernate so nothing moves while powered down.
   always_ff @(posedge MCLK)
   begin
      if (!HOST_RESET_N)
      begin
         tick_cnt <= 16'h0000;
         ms_tick  <= 1'b0;
      end
      else if (mode == MODE_HIBERNATE)
      begin
         ms_tick <= 1'b0;
      end
      else if (tick_cnt == 16'(TICK_CYCLES - 1))
      begin
         tick_cnt <= 16'h0000;
         ms_tick  <= 1'b1;
      end
      else
      begin
         tick_cnt <= tick_cnt + 16'h0001;
         ms_tick  <= 1'b0;
      end
   end

   always_ff @(posedge MCLK)
   begin
      if (!HOST_RESET_N)
      begin
         init_cnt  <= 16'h0000;
         init_done <= 1'b0;
      end
      else if (ms_tick && !init_done)
      begin
         init_cnt <= init_cnt + 16'h0001;
         if (init_cnt == 16'(INIT_TICKS - 1))
         begin
            init_done <= 1'b1;
         end
      end
   end

   // ****************************************************************
   // Frame pacing
   // ****************************************************************
   // Each tick adds the frame rate to a phase; a wrap at one thousand
   // gives exactly that many frames per second without a divider.
   always_comb
   begin
      next_phase = phase + ((mode == MODE_ACTIVE) ? {3'b000, act_fps}
                                                  : {3'b000, mon_fps});
      scan_due   = 1'b0;
      if (next_phase >= PHASE_WRAP)
      begin
         next_phase = next_phase - PHASE_WRAP;
         scan_due   = 1'b1;
      end
   end

   always_ff @(posedge MCLK)
   begin
      if (!HOST_RESET_N)
      begin
         phase <= 11'h000;
      end
      else if (ms_tick && init_done)
      begin
         phase <= next_phase;
      end
   end

   // A frame that falls due while the previous scan still runs is
   // dropped rather than queued, so a slow front end lowers the rate.
   always_ff @(posedge MCLK)
   begin
      if (!HOST_RESET_N || mode == MODE_HIBERNATE)
      begin
         PFE_SCAN_START <= 1'b0;
         scan_busy      <= 1'b0;
      end
      else
      begin
         PFE_SCAN_START <= 1'b0;
         if (ms_tick && init_done && scan_due && !scan_busy)
         begin
            PFE_SCAN_START <= 1'b1;
            scan_busy      <= 1'b1;
         end
         else if (PFE_DONE)
         begin
            scan_busy <= 1'b0;
         end
      end
   end

   // ****************************************************************
   // Operating mode
   // ****************************************************************
   // Only reset leaves hibernate; the sync reset is the wake path.
   always_ff @(posedge MCLK)
   begin
      if (!HOST_RESET_N)
      begin
         mode <= MODE_ACTIVE;
      end
      else if (mode == MODE_MONITOR && done_ok && PFE_TOUCH)
      begin
         mode <= MODE_ACTIVE;
      end
      else if (reg_wr && ptr == REG_MODE && wr_data[1:0] != 2'b11)
      begin
         mode <= tpc_mode_t'(wr_data[1:0]);
      end
   end

   always_ff @(posedge MCLK)
   begin
      if (!HOST_RESET_N)
      begin
         act_fps <= ACT_FPS_RST;
         mon_fps <= MON_FPS_RST;
      end
      else if (reg_wr && ptr == REG_ACT_FPS)
      begin
         act_fps <= wr_data;
      end
      else if (reg_wr && ptr == REG_MON_FPS)
      begin
         mon_fps <= wr_data;
      end
   end

   // ****************************************************************
   // Register pointer and read data
   // ****************************************************************
   always_ff @(posedge MCLK)
   begin
      if (!HOST_RESET_N)
      begin
         ptr <= 8'h00;
      end
      else if (wr_valid && wr_first)
      begin
         ptr <= wr_data;
      end
      else if (reg_wr || rd_take)
      begin
         ptr <= ptr + 8'h01;
      end
   end

   always_comb
   begin
      unique case (ptr)
         REG_MODE:    rd_data = {6'b000000, mode};
         REG_ACT_FPS: rd_data = act_fps;
         REG_MON_FPS: rd_data = mon_fps;
         REG_STATUS:  rd_data = {6'b000000, touched, data_ready};
         REG_X_HI:    rd_data = {4'h0, x_pos[11:8]};
         REG_X_LO:    rd_data = x_pos[7:0];
         REG_Y_HI:    rd_data = {4'h0, y_pos[11:8]};
         REG_Y_LO:    rd_data = y_pos[7:0];
         default:     rd_data = 8'h00;
      endcase
   end

   // ****************************************************************
   // Touch data and interrupt
   // ****************************************************************
   // Only full scans in active mode deliver coordinates; the monitor
   // presence check carries no position.  An empty frame keeps the last
   // coordinates, so a host still reading them never sees them replaced
   // by the noise of a frame without a touch.
   always_ff @(posedge MCLK)
   begin
      if (!HOST_RESET_N)
      begin
         x_pos   <= 12'h000;
         y_pos   <= 12'h000;
         touched <= 1'b0;
      end
      else if (done_ok && mode == MODE_ACTIVE)
      begin
         touched <= PFE_TOUCH;
         if (PFE_TOUCH)
         begin
            x_pos <= PFE_X;
            y_pos <= PFE_Y;
         end
      end
   end

   // A new scan result wins over the read that clears the flag.
   always_ff @(posedge MCLK)
   begin
      if (!HOST_RESET_N)
      begin
         data_ready <= 1'b0;
      end
      else if (done_ok && mode == MODE_ACTIVE && PFE_TOUCH)
      begin
         data_ready <= 1'b1;
      end
      else if (rd_take && ptr == REG_Y_LO)
      begin
         data_ready <= 1'b0;
      end
   end

   always_ff @(posedge MCLK)
   begin
      if (!HOST_RESET_N)
      begin
         TOUCH_IRQ_N <= 1'b1;
      end
      else
      begin
         TOUCH_IRQ_N <= !(data_ready && init_done && mode == MODE_ACTIVE);
      end
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   a_reset_active : assert property (
      @(posedge MCLK)
      !HOST_RESET_N |=> (mode == MODE_ACTIVE && !init_done && TOUCH_IRQ_N))
      else $error("Reset did not restart in active mode.");

   a_monitor_wake : assert property (
      @(posedge MCLK) disable iff (!HOST_RESET_N)
      (mode == MODE_MONITOR && done_ok && PFE_TOUCH)
      |=> (mode == MODE_ACTIVE))
      else $error("Monitor touch did not wake to active.");

   a_port_closed : assert property (
      @(posedge MCLK) disable iff (!HOST_RESET_N)
      (mode != MODE_ACTIVE)[*2] |-> !SDA_OE)
      else $error("Serial port answered outside active mode.");

   a_hib_silent : assert property (
      @(posedge MCLK) disable iff (!HOST_RESET_N)
      (mode == MODE_HIBERNATE)
      |=> (mode == MODE_HIBERNATE && !PFE_SCAN_START && !ms_tick))
      else $error("Hibernate reacted to something other than reset.");

   a_irq_on_data : assert property (
      @(posedge MCLK) disable iff (!HOST_RESET_N)
      (data_ready && init_done && mode == MODE_ACTIVE) |=> !TOUCH_IRQ_N)
      else $error("Ready touch data raised no interrupt.");

   a_init_quiet : assert property (
      @(posedge MCLK) disable iff (!HOST_RESET_N)
      !init_done |-> (TOUCH_IRQ_N && !PFE_SCAN_START && !port_en))
      else $error("Activity before start-up finished.");

   a_irq_gated : assert property (
      @(posedge MCLK) disable iff (!HOST_RESET_N)
      (mode != MODE_ACTIVE || !data_ready) |=> TOUCH_IRQ_N)
      else $error("Interrupt asserted without data or outside active.");

   a_scan_on_tick : assert property (
      @(posedge MCLK) disable iff (!HOST_RESET_N)
      PFE_SCAN_START |-> ($past(ms_tick) && $past(scan_due) && scan_busy))
      else $error("Scan started off the frame pacing.");

   a_monitor_nocap : assert property (
      @(posedge MCLK) disable iff (!HOST_RESET_N)
      (mode == MODE_MONITOR && PFE_DONE)
      |-> (!PFE_FULL_SCAN ##1 ($stable(x_pos) && $stable(y_pos))))
      else $error("Monitor scan captured coordinates.");
endmodule : tpc_mode_ctrl

`default_nettype wire

// ===== rtl/tpc_i2c_target.sv
`default_nettype none

package tpc_pkg;
   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int unsigned CLK_HZ          = 25_000_000;
   localparam int unsigned TICK_TIME_US    = 1000;
   localparam int unsigned TICK_CYCLES_DFLT =
      CLK_HZ / 1_000_000 * TICK_TIME_US;
   localparam int unsigned INIT_TIME_MS    = 200;
   localparam int unsigned INIT_TICKS_DFLT =
      INIT_TIME_MS * 1000 / TICK_TIME_US;
   localparam logic [10:0] PHASE_WRAP      = 11'h03E8;
   // ****************************************************************
   // Register map seen through the serial port
   // ****************************************************************
   localparam logic [7:0] REG_MODE     = 8'h00;
   localparam logic [7:0] REG_ACT_FPS  = 8'h01;
   localparam logic [7:0] REG_MON_FPS  = 8'h02;
   localparam logic [7:0] REG_STATUS   = 8'h03;
   localparam logic [7:0] REG_X_HI     = 8'h04;
   localparam logic [7:0] REG_X_LO     = 8'h05;
   localparam logic [7:0] REG_Y_HI     = 8'h06;
   localparam logic [7:0] REG_Y_LO     = 8'h07;
   localparam logic [7:0] ACT_FPS_RST  = 8'h0064;
   localparam logic [7:0] MON_FPS_RST  = 8'h0019;
   // The target address is arbitrary.
   localparam logic [6:0] TARGET_ADDR  = 7'h002A;
   localparam logic [3:0] BITS_PER_BYTE = 4'h0008;
   // ****************************************************************
   // Types
   // ****************************************************************
   typedef enum logic [1:0] {
      MODE_ACTIVE,
      MODE_MONITOR,
      MODE_HIBERNATE
   } tpc_mode_t;
   typedef enum logic [2:0] {
      I2C_IDLE,
      I2C_ADDR,
      I2C_AACK,
      I2C_WRITE,
      I2C_WACK,
      I2C_READ,
      I2C_RACK
   } tpc_i2c_state_t;
endpackage : tpc_pkg

module tpc_i2c_target
(
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       enable,
   input  wire logic       scl,
   input  wire logic       sda,
   output logic            sda_oe,
   output logic            wr_valid,
   output logic            wr_first,
   output logic [7:0]      wr_data,
   output logic            rd_take,
   input  wire logic [7:0] rd_data
);
   import tpc_pkg::*;

   tpc_i2c_state_t st;
   logic           scl_q;
   logic           sda_q;
   logic [7:0]     sh;
   logic [3:0]     cnt;
   logic           is_read;
   logic           first;
   logic           start;
   logic           stop;
   logic           rise;
   logic           fall;

   assign start = scl & scl_q & sda_q & ~sda;
   assign stop  = scl & scl_q & ~sda_q & sda;
   assign rise  = scl & ~scl_q;
   assign fall  = ~scl & scl_q;

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end
      else
      begin
         scl_q <= scl;
         sda_q <= sda;
      end
   end

   // ****************************************************************
   // Byte engine
   // ****************************************************************
   // The port only ever pulls SDA low and never drives SCL.
   always_ff @(posedge clk)
   begin
      if (!rst_n || !enable)
      begin
         st       <= I2C_IDLE;
         sda_oe   <= 1'b0;
         cnt      <= 4'h0;
         sh       <= 8'h00;
         is_read  <= 1'b0;
         first    <= 1'b0;
         wr_valid <= 1'b0;
         wr_first <= 1'b0;
         wr_data  <= 8'h00;
         rd_take  <= 1'b0;
      end
      else
      begin
         wr_valid <= 1'b0;
         rd_take  <= 1'b0;
         if (start)
         begin
            st     <= I2C_ADDR;
            cnt    <= 4'h0;
            sda_oe <= 1'b0;
         end
         else if (stop)
         begin
            st     <= I2C_IDLE;
            sda_oe <= 1'b0;
         end
         else
         begin
            unique case (st)
               I2C_IDLE:
               begin
               end
               I2C_ADDR, I2C_WRITE:
               begin
                  if (rise)
                  begin
                     sh  <= {sh[6:0], sda};
                     cnt <= cnt + 4'h1;
                  end
                  else if (fall && cnt == BITS_PER_BYTE)
                  begin
                     cnt <= 4'h0;
                     if (st == I2C_ADDR)
                     begin
                        if (sh[7:1] == TARGET_ADDR)
                        begin
                           st      <= I2C_AACK;
                           sda_oe  <= 1'b1;
                           is_read <= sh[0];
                           first   <= 1'b1;
                        end
                        else
                        begin
                           st <= I2C_IDLE;
                        end
                     end
                     else
                     begin
                        st       <= I2C_WACK;
                        sda_oe   <= 1'b1;
                        wr_valid <= 1'b1;
                        wr_first <= first;
                        wr_data  <= sh;
                        first    <= 1'b0;
                     end
                  end
               end
               I2C_AACK, I2C_WACK:
               begin
                  if (fall)
                  begin
                     if (st == I2C_AACK && is_read)
                     begin
                        st      <= I2C_READ;
                        sh      <= rd_data;
                        sda_oe  <= ~rd_data[7];
                        rd_take <= 1'b1;
                     end
                     else
                     begin
                        st     <= I2C_WRITE;
                        sda_oe <= 1'b0;
                     end
                  end
               end
               I2C_READ:
               begin
                  if (rise)
                  begin
                     cnt <= cnt + 4'h1;
                  end
                  else if (fall)
                  begin
                     if (cnt == BITS_PER_BYTE)
                     begin
                        st     <= I2C_RACK;
                        sda_oe <= 1'b0;
                        cnt    <= 4'h0;
                     end
                     else
                     begin
                        sda_oe <= ~sh[6];
                        sh     <= {sh[6:0], 1'b0};
                     end
                  end
               end
               I2C_RACK:
               begin
                  if (rise && sda)
                  begin
                     st <= I2C_IDLE;
                  end
                  else if (fall)
                  begin
                     st      <= I2C_READ;
                     sh      <= rd_data;
                     sda_oe  <= ~rd_data[7];
                     rd_take <= 1'b1;
                  end
               end
            endcase
         end
      end
   end

   a_idle_released : assert property (
      @(posedge clk) disable iff (!rst_n)
      (st == I2C_IDLE) |-> !sda_oe)
      else $error("Target drives SDA while idle.");

   a_restart_packet : assert property (
      @(posedge clk) disable iff (!rst_n)
      (start && enable) |=> (st == I2C_ADDR && cnt == 4'h0))
      else $error("Start did not open a new packet.");

   a_write_dir_acks : assert property (
      @(posedge clk) disable iff (!rst_n)
      (st == I2C_AACK && !is_read && fall && enable && !start && !stop)
      |=> (st == I2C_WRITE && !sda_oe))
      else $error("Write direction did not enter write state.");
endmodule : tpc_i2c_target

`default_nettype wire

// ===== testbench/tpc_host_model.sv
`default_nettype none
// ************************************************************
// Host side of the serial bus
// ************************************************************
// Each level is held five clocks so the target sees it twice.
module tpc_host_model
(
   input  wire logic clk,
   input  wire logic sda,
   output logic      scl,
   output logic      sda_low
);
   timeunit 1ns;
   timeprecision 1ns;
   initial
   begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   task automatic half(input logic c, input logic d);
      @(posedge clk);
      scl <= c;
      sda_low <= ~d;
      repeat (4) @(posedge clk);
   endtask : half
   // Also serves as a repeated start that closes the packet.
   task automatic start;
      half(1'b0, 1'b1);
      half(1'b1, 1'b1);
      half(1'b1, 1'b0);
   endtask : start
   task automatic stop;
      half(1'b0, 1'b0);
      half(1'b1, 1'b0);
      half(1'b1, 1'b1);
   endtask : stop
   // Eight bits then the acknowledge slot; a one releases the line.
   task automatic xfer(input logic [8:0] w, output logic [8:0] r);
      for (int i = 8; i >= 0; i--)
      begin
         half(1'b0, w[i]);
         half(1'b1, w[i]);
         r[i] = sda;
      end
   endtask : xfer
endmodule : tpc_host_model
`default_nettype wire

// ===== testbench/tpc_mode_ctrl_tb.sv
`default_nettype none
module tpc_mode_ctrl_tb;
   import tpc_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic        mclk = 1'b0;
   logic        host_reset_n = 1'b0;
   logic        scl, sda_low, sda_o, sda_oe, irq_n;
   logic        pfe_start, pfe_full, pfe_pd;
   logic        pfe_done = 1'b0;
   logic        pfe_touch = 1'b0;
   logic        touch_en = 1'b0;
   logic [11:0] pfe_x = 12'h0000;
   logic [11:0] pfe_y = 12'h0000;
   logic [2:0]  sh = 3'h0;
   logic [31:0] rnd = 32'h0000_003A;
   tpc_mode_t   mode;
   int          fail_count = 0;
   int          n_tests = 0;
   int          mdl_mode = 0;
   int          mdl_x, mdl_y;
   // SDA has a pull-up; either party may pull it low.
   wire logic   sda = ~(sda_low | (sda_oe & ~sda_o));

   always #20 mclk = ~mclk;

   tpc_mode_ctrl #(.TICK_CYCLES(20), .INIT_TICKS(3)) u_dut
   (
      .MCLK(mclk), .HOST_RESET_N(host_reset_n), .SCL_I(scl), .SDA_I(sda),
      .SDA_O(sda_o), .SDA_OE(sda_oe), .TOUCH_IRQ_N(irq_n), .MODE(mode),
      .PFE_SCAN_START(pfe_start), .PFE_FULL_SCAN(pfe_full),
      .PFE_POWER_DOWN(pfe_pd), .PFE_DONE(pfe_done),
      .PFE_TOUCH(pfe_touch), .PFE_X(pfe_x), .PFE_Y(pfe_y)
   );
   tpc_host_model u_host
   (
      .clk(mclk), .sda(sda), .scl(scl), .sda_low(sda_low)
   );

   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction : xs

   // ************************************************************
   // Front end stand-in: every scan ends four clocks later
   // ************************************************************
   always @(posedge mclk)
   begin
      rnd <= xs(rnd);
      pfe_x <= rnd[11:0];
      pfe_y <= rnd[27:16];
      sh <= {sh[1:0], pfe_start};
      pfe_done <= sh[2];
      pfe_touch <= sh[2] & touch_en;
   end

   task automatic check(input logic [11:0] seen, input logic [11:0] exp,
                        input string what);
      n_tests++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : check

   task automatic stop_test;
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : stop_test

   // The host keeps off the bus for the whole start-up.
   task automatic reset;
      int e;
      e = 0;
      host_reset_n <= 1'b0;
      repeat (3) @(posedge mclk);
      host_reset_n <= 1'b1;
      mdl_mode = 0;
      repeat (55)
      begin
         @(posedge mclk);
         e += (pfe_start !== 1'b0) + (irq_n !== 1'b1) + (sda_oe !== 1'b0);
      end
      check(12'(e), 12'h000, "init quiet");
      repeat (20) @(posedge mclk);
      check(12'(mode), 12'(mdl_mode), "mode");
   endtask : reset

   task automatic wr(input logic [7:0] p, input logic [7:0] v);
      logic [8:0] r;
      u_host.start();
      u_host.xfer({TARGET_ADDR, 1'b0, 1'b1}, r);
      check(12'(r[0]), 12'h000, "write ack");
      u_host.xfer({p, 1'b1}, r);
      u_host.xfer({v, 1'b1}, r);
      u_host.stop();
      if (p == REG_MODE && v < 3)
         mdl_mode = int'(v);
      repeat (2) @(posedge mclk);
      check(12'(mode), 12'(mdl_mode), "mode");
   endtask : wr

   task automatic rd(input logic [7:0] p, input int e[$]);
      logic [8:0] r;
      u_host.start();
      u_host.xfer({TARGET_ADDR, 1'b0, 1'b1}, r);
      u_host.xfer({p, 1'b1}, r);
      u_host.start();
      u_host.xfer({TARGET_ADDR, 1'b1, 1'b1}, r);
      check(12'(r[0]), 12'h000, "read ack");
      foreach (e[i])
      begin
         u_host.xfer({8'hFF, 1'(i == e.size() - 1)}, r);
         check(12'(r[8:1]), 12'(e[i]), "read byte");
      end
      u_host.stop();
   endtask : rd

   task automatic probe(input logic [6:0] a);
      logic [8:0] r;
      u_host.start();
      u_host.xfer({a, 1'b0, 1'b1}, r);
      u_host.stop();
      check(12'(r[0]), 12'h001, "no ack");
   endtask : probe

   task automatic rate(input int exp);
      int n;
      n = 0;
      repeat (4000)
      begin
         @(posedge mclk);
         n += int'(pfe_start);
      end
      check(12'(n >= exp - 1 && n <= exp + 1), 12'h001, "rate");
   endtask : rate

   task automatic touch;
      touch_en <= 1'b1;
      for (int i = 0; i < 2000; i++)
      begin
         @(posedge mclk);
         if (pfe_done && pfe_touch)
            break;
      end
      touch_en <= 1'b0;
      if (pfe_done && pfe_touch && mdl_mode == 1)
         mdl_mode = 0;
      else if (pfe_done && pfe_touch && mdl_mode == 0)
      begin
         mdl_x = int'(pfe_x);
         mdl_y = int'(pfe_y);
      end
      repeat (3) @(posedge mclk);
      check(12'(mode), 12'(mdl_mode), "mode");
   endtask : touch

   // ************************************************************
   // Main sequence
   // ************************************************************
   initial
   begin
      reset();
      rd(REG_ACT_FPS, '{100, 25});
      rate(20);
      wr(REG_ACT_FPS, 8'h32);
      rate(10);
      wr(REG_MODE, 8'h03);
      probe(7'h2B);
      $display("test active done");
      touch();
      check(12'(irq_n), 12'h000, "irq");
      rd(REG_X_HI, '{mdl_x >> 8, mdl_x & 255, mdl_y >> 8, mdl_y & 255});
      repeat (3) @(posedge mclk);
      check(12'(irq_n), 12'h001, "irq idle");
      $display("test touch done");
      wr(REG_MODE, 8'h01);
      check(12'(pfe_full), 12'h000, "full scan");
      rate(5);
      probe(TARGET_ADDR);
      touch();
      check(12'(irq_n), 12'h001, "irq idle");
      $display("test monitor done");
      wr(REG_MODE, 8'h02);
      check(12'(pfe_pd), 12'h001, "power down");
      probe(TARGET_ADDR);
      touch();
      reset();
      rd(REG_ACT_FPS, '{100});
      $display("test hibernate done");
      stop_test();
   end

   initial
   begin
      repeat (50000) @(posedge mclk);
      fail_count++;
      stop_test();
   end
endmodule : tpc_mode_ctrl_tb
`default_nettype wire
